//--- sefs_pkg.sv
// Function
// - Four stages; stage one definite or inverse.
// - Per-stage forward, reverse or non-directional selector.
// - Stage one definite trip after delay.
// - Stage one offers IEC, IEEE, US, configurable curves.
// - Inverse operate time scaled by time multiplier.
// - Dependent reset only with IEEE or US curves.
// - Definite reset clears inverse state after delay.
// - Dependent reset time scaled by reset multiplier.
// - Stage one second trip via own timer.
// - Second trip needs continued operation after first.
// - Second trip needs its enable switch on.
// - Stages two to four trip/alarm after delays.
// - Stage inhibited by enable off or block.
// - Each stage gives an undelayed instant trip.
// - High-speed stage one pickup output, undelayed.
// - Residual power restraint requires power above threshold.
// - Direction needs residual voltage at or above polarising level.
// - Comparators use fundamental-frequency current only.
// - Thresholds cover 10 mA to 1 A.
package sefs_pkg;
  localparam int DW = 16;
  localparam int AW = 5;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [AW-1:0] CTRL_IDX   = 5'h00;
  localparam logic [AW-1:0] DIRC_IDX   = 5'h01;
  localparam logic [AW-1:0] THR_IDX    = 5'h02;
  localparam logic [AW-1:0] DLY_IDX    = 5'h06;
  localparam logic [AW-1:0] DLY12_IDX  = 5'h0A;
  localparam logic [AW-1:0] TMS_IDX    = 5'h0B;
  localparam logic [AW-1:0] TRST_IDX   = 5'h0C;
  localparam logic [AW-1:0] RM_IDX     = 5'h0D;
  localparam logic [AW-1:0] RP_IDX     = 5'h0E;
  localparam logic [AW-1:0] SEV_IDX    = 5'h0F;
  localparam logic [AW-1:0] STAT_IDX   = 5'h10;
  localparam logic [DW-1:0] THR_RST    = 16'h0032;
  localparam logic [DW-1:0] DLY_RST    = 16'h0064;
  localparam logic [DW-1:0] MULT_RST   = 16'h03E8;
  localparam logic [DW-1:0] SEV_RST    = 16'h001E;
  localparam logic [DW-1:0] DEP_STEP   = 16'h03E8;
  localparam logic [31:0]   INV_UNIT   = 32'h0000_0400;
  localparam logic [31:0]   RESET_DEC  = 32'h0000_0001;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TIMER_STEP_MS = 10;
  localparam int unsigned RESET_STEP_MS = 100;
  localparam int unsigned TICK_DFLT     = TIMER_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0]  TICKS_PER_RS  = 4'(RESET_STEP_MS / TIMER_STEP_MS);
  typedef enum logic [1:0] {DIR_FWD, DIR_REV, DIR_NON} sefs_dir_t;
  typedef enum logic [2:0] {CHAR_DT, CHAR_IEC, CHAR_IEEE, CHAR_US, CHAR_CON} sefs_char_t;
  typedef struct packed {
    logic [1:0] pad;
    logic       reset_dep;
    sefs_char_t char_sel;
    logic [3:0] vtf_blk;
    logic       rp_en;
    logic       s2_en;
    logic [3:0] en;
  } sefs_ctrl_t;
  typedef struct packed {
    logic [4:0]      pad;
    logic [2:0]      curve;
    sefs_dir_t [3:0] dir;
  } sefs_dirc_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } sefs_bus_t;
  typedef struct packed {
    logic [DW-1:0] current;
    logic [DW-1:0] voltage;
    logic [DW-1:0] power;
    logic          fwd;
    logic          rev;
    logic [DW-1:0] curve_rate;
  } sefs_meas_t;
  typedef struct packed {
    logic [3:0] instant_trip;
    logic       stage1_high_speed_pickup;
    logic       stage4_alarm;
    logic       stage3_trip;
    logic       stage2_trip;
    logic       stage1_second_trip;
    logic       stage1_trip;
  } sefs_out_t;
  typedef struct packed {
    sefs_ctrl_t         ctrl;
    sefs_dirc_t         dirc;
    logic [3:0][DW-1:0] thr;
    logic [3:0][DW-1:0] dly;
    logic [DW-1:0]      dly12;
    logic [DW-1:0]      tms;
    logic [DW-1:0]      trst;
    logic [DW-1:0]      rm;
    logic [DW-1:0]      rp;
    logic [DW-1:0]      polarising_voltage_level;
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    logic [31:0]        tick_cnt;
    logic               tick;
    logic [3:0][DW-1:0] cnt;
    logic [DW-1:0]      s2cnt;
    logic [31:0]        acc;
    logic [19:0]        rcnt;
    logic [DW-1:0]      sub;
    sefs_out_t          out;
    logic [DW-1:0]      rdata;
  } sefs_state_t;
  localparam sefs_ctrl_t  CTRL_RST = '{char_sel: CHAR_DT, default: '0};
  localparam sefs_dirc_t  DIRC_RST = '{dir: {4{DIR_FWD}}, default: '0};
  localparam sefs_state_t STATE_RST = '{ctrl: CTRL_RST, dirc: DIRC_RST, thr: {4{THR_RST}},
    dly: {4{DLY_RST}}, dly12: DLY_RST, tms: MULT_RST, rm: MULT_RST, polarising_voltage_level: SEV_RST, default: '0};
endpackage

//--- sefs_scheme.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module sefs_scheme import sefs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_DFLT
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          nrst,
  // Register port
  input  wire sefs_bus_t     bus,
  output logic [DW-1:0]      rdata,
  // Measurement front end
  input  wire sefs_meas_t    meas,
  output sefs_char_t         curve_family,
  output logic [2:0]         inverse_curve_select,
  // Pins
  input  wire logic [3:0]    block_input,
  input  wire logic          vt_failure,
  // Protection outputs
  output sefs_out_t          prot
);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  sefs_state_t state_r;
  sefs_state_t state_nxt;
  logic [3:0]  pick;
  logic [3:0]  dir_ok;
  logic [3:0]  blk_s;
  logic        vtf_s;
  logic        pol_ok;
  logic        rp_ok;
  logic        inverse;
  logic        dep_reset;
  logic [31:0] op_level;
  logic [32:0] acc_sum;
  logic [19:0] reset_ticks;
  logic [3:0]  dt_done;
  logic        s2_done;

  // ****************************************
  // Stage pickup
  // ****************************************
  assign blk_s   = state_r.sync2[3:0];
  assign vtf_s   = state_r.sync2[4];
  assign pol_ok  = meas.voltage >= state_r.polarising_voltage_level;
  assign rp_ok   = !state_r.ctrl.rp_en || (meas.power > state_r.rp);

  for (genvar g = 0; g < 4; g++) begin : g_stage
    // An undefined direction code never picks up, so a bad write fails safe.
    assign dir_ok[g] = (state_r.dirc.dir[g] == DIR_NON) ||
                       (pol_ok && ((state_r.dirc.dir[g] == DIR_FWD && meas.fwd) ||
                                   (state_r.dirc.dir[g] == DIR_REV && meas.rev)));
    // The current is the fundamental magnitude in mA from the filter.
    assign pick[g] = state_r.ctrl.en[g] && !blk_s[g] &&
                     !(state_r.ctrl.vtf_blk[g] && vtf_s) &&
                     (meas.current >= state_r.thr[g]) && dir_ok[g] && rp_ok;
    // Ticks run free, so the first one may fall just after pickup; one extra tick is
    // counted so that the delay is never cut short by up to a whole step.
    assign dt_done[g] = (state_r.dly[g] == '0) || (state_r.cnt[g] > state_r.dly[g]) ||
                        (state_r.cnt[g] == '1);
  end

  // ****************************************
  // Stage one characteristic
  // ****************************************
  assign inverse   = state_r.ctrl.char_sel inside {CHAR_IEC, CHAR_IEEE, CHAR_US, CHAR_CON};
  assign dep_reset = state_r.ctrl.reset_dep &&
                     (state_r.ctrl.char_sel inside {CHAR_IEEE, CHAR_US});
  assign op_level  = 32'(state_r.tms) * INV_UNIT;
  assign acc_sum   = {1'b0, state_r.acc} + 33'(meas.curve_rate);
  assign reset_ticks = 20'(state_r.trst) * 20'(TICKS_PER_RS);
  assign s2_done   = (state_r.dly12 == '0) || (state_r.s2cnt > state_r.dly12) ||
                     (state_r.s2cnt == '1);

  always_comb begin
    state_nxt       = state_r;
    state_nxt.sync1 = {vt_failure, block_input};
    state_nxt.sync2 = state_r.sync1;
    state_nxt.tick  = 1'b0;
    if (state_r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      state_nxt.tick_cnt = '0;
      state_nxt.tick     = 1'b1;
    end else begin
      state_nxt.tick_cnt = state_r.tick_cnt + 32'd1;
    end

    // Register writes.
    if (bus.wr) begin
      if (bus.addr == CTRL_IDX) begin
        state_nxt.ctrl = sefs_ctrl_t'(bus.wdata);
      end else if (bus.addr == DIRC_IDX) begin
        state_nxt.dirc = sefs_dirc_t'(bus.wdata);
      end else if (bus.addr >= THR_IDX && bus.addr < DLY_IDX) begin
        state_nxt.thr[2'(bus.addr - THR_IDX)] = bus.wdata;
      end else if (bus.addr >= DLY_IDX && bus.addr < DLY12_IDX) begin
        state_nxt.dly[2'(bus.addr - DLY_IDX)] = bus.wdata;
      end else if (bus.addr == DLY12_IDX) begin
        state_nxt.dly12 = bus.wdata;
      end else if (bus.addr == TMS_IDX) begin
        state_nxt.tms = bus.wdata;
      end else if (bus.addr == TRST_IDX) begin
        state_nxt.trst = bus.wdata;
      end else if (bus.addr == RM_IDX) begin
        state_nxt.rm = bus.wdata;
      end else if (bus.addr == RP_IDX) begin
        state_nxt.rp = bus.wdata;
      end else if (bus.addr == SEV_IDX) begin
        state_nxt.polarising_voltage_level = bus.wdata;
      end
    end

    // Register reads; unmapped addresses return zero.
    state_nxt.rdata = '0;
    if (bus.rd) begin
      if (bus.addr == CTRL_IDX) begin
        state_nxt.rdata = DW'(state_r.ctrl);
      end else if (bus.addr == DIRC_IDX) begin
        state_nxt.rdata = DW'(state_r.dirc);
      end else if (bus.addr >= THR_IDX && bus.addr < DLY_IDX) begin
        state_nxt.rdata = state_r.thr[2'(bus.addr - THR_IDX)];
      end else if (bus.addr >= DLY_IDX && bus.addr < DLY12_IDX) begin
        state_nxt.rdata = state_r.dly[2'(bus.addr - DLY_IDX)];
      end else if (bus.addr == DLY12_IDX) begin
        state_nxt.rdata = state_r.dly12;
      end else if (bus.addr == TMS_IDX) begin
        state_nxt.rdata = state_r.tms;
      end else if (bus.addr == TRST_IDX) begin
        state_nxt.rdata = state_r.trst;
      end else if (bus.addr == RM_IDX) begin
        state_nxt.rdata = state_r.rm;
      end else if (bus.addr == RP_IDX) begin
        state_nxt.rdata = state_r.rp;
      end else if (bus.addr == SEV_IDX) begin
        state_nxt.rdata = state_r.polarising_voltage_level;
      end else if (bus.addr == STAT_IDX) begin
        state_nxt.rdata = DW'(state_r.out);
      end
    end

    // Definite delay timers count 10 ms ticks and hold one tick past their setting.
    for (int i = 0; i < 4; i++) begin
      if (!pick[i]) begin
        state_nxt.cnt[i] = '0;
      end else if (state_r.tick && state_r.cnt[i] <= state_r.dly[i] && state_r.cnt[i] != '1) begin
        // An all-ones setting saturates one tick early, far beyond the usable range.
        state_nxt.cnt[i] = state_r.cnt[i] + 16'd1;
      end
    end

    // The second-trip timer only runs while the first-stage trip stands.
    if (!(pick[0] && state_r.out.stage1_trip)) begin
      state_nxt.s2cnt = '0;
    end else if (state_r.tick && state_r.s2cnt <= state_r.dly12 && state_r.s2cnt != '1) begin
      state_nxt.s2cnt = state_r.s2cnt + 16'd1;
    end

    // Inverse integrator: the curve evaluator supplies the rate per tick.
    if (!inverse) begin
      state_nxt.acc  = '0;
      state_nxt.rcnt = '0;
      state_nxt.sub  = '0;
    end else if (pick[0]) begin
      state_nxt.rcnt = '0;
      state_nxt.sub  = '0;
      if (state_r.tick) begin
        state_nxt.acc = (acc_sum >= {1'b0, op_level}) ? op_level : acc_sum[31:0];
      end
    end else if (dep_reset) begin
      state_nxt.rcnt = '0;
      // Each tick adds a fixed credit; each spent reset multiplier step
      // removes one decrement, so reset time scales with the multiplier.
      if (state_r.tick) begin
        state_nxt.sub = state_r.sub + DEP_STEP;
      end else if (state_r.rm != '0 && state_r.sub >= state_r.rm) begin
        state_nxt.sub = state_r.sub - state_r.rm;
        state_nxt.acc = (state_r.acc > RESET_DEC) ? state_r.acc - RESET_DEC : '0;
      end
    end else begin
      state_nxt.sub = '0;
      if (state_r.rcnt >= reset_ticks) begin
        state_nxt.acc = '0;
      end else if (state_r.tick) begin
        state_nxt.rcnt = state_r.rcnt + 20'd1;
      end
    end

    // Outputs.
    state_nxt.out.instant_trip             = pick;
    state_nxt.out.stage1_high_speed_pickup = pick[0];
    state_nxt.out.stage1_trip = pick[0] && (inverse ? (state_r.acc >= op_level)
                                                    : dt_done[0]);
    state_nxt.out.stage1_second_trip = state_r.ctrl.s2_en && pick[0] &&
                                       state_r.out.stage1_trip && s2_done;
    state_nxt.out.stage2_trip  = pick[1] && dt_done[1];
    state_nxt.out.stage3_trip  = pick[2] && dt_done[2];
    state_nxt.out.stage4_alarm = pick[3] && dt_done[3];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata                = state_r.rdata;
  assign prot                 = state_r.out;
  assign curve_family         = state_r.ctrl.char_sel;
  assign inverse_curve_select = state_r.dirc.curve;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_ENABLE_OFF: assert property (!state_r.ctrl.en[1] |=> !prot.stage2_trip && !prot.instant_trip[1])
    else $error("Stage two output while disabled");
  AST_BLOCK_IN: assert property (blk_s[2] |=> !prot.stage3_trip && !prot.instant_trip[2])
    else $error("Stage three output while blocked");
  AST_VTF_BLOCK: assert property (state_r.ctrl.vtf_blk[3] && vtf_s |=> !prot.stage4_alarm)
    else $error("Stage four alarm during voltage failure block");
  AST_DIR_FWD: assert property (state_r.dirc.dir[0] == DIR_FWD && !meas.fwd |=> !prot.instant_trip[0])
    else $error("Forward stage picked up without forward fault");
  AST_POL_LEVEL: assert property (state_r.dirc.dir[1] != DIR_NON && meas.voltage < state_r.polarising_voltage_level
                                  |=> !prot.instant_trip[1])
    else $error("Directional pickup below polarising level");
  AST_RP_RESTRAIN: assert property (state_r.ctrl.rp_en && meas.power <= state_r.rp
                                    |=> prot.instant_trip == 4'h0)
    else $error("Pickup with residual power below threshold");
  AST_INST: assert property (1'b1 |=> prot.instant_trip == $past(pick))
    else $error("Instant trip does not follow pickup");
  AST_HS: assert property (pick[0] |=> prot.stage1_high_speed_pickup)
    else $error("High speed pickup missing");
  AST_S2_ENABLE: assert property (!state_r.ctrl.s2_en |=> !prot.stage1_second_trip)
    else $error("Second trip while its enable is off");
  AST_S2_AFTER_S1: assert property (prot.stage1_second_trip |-> $past(prot.stage1_trip) && prot.stage1_trip)
    else $error("Second trip without first trip");
  AST_DT_ZERO: assert property (pick[2] && state_r.dly[2] == 16'h0000 |=> prot.stage3_trip)
    else $error("Zero delay stage three trip missing");
  AST_DT1_ZERO: assert property (state_r.ctrl.char_sel == CHAR_DT && pick[0] && state_r.dly[0] == 16'h0000
                                 |=> prot.stage1_trip)
    else $error("Zero delay stage one trip missing");
  AST_RESTART: assert property (!pick[1] |=> state_r.cnt[1] == 16'h0000)
    else $error("Stage two timer not restarted");
  AST_DEF_RESET: assert property (inverse && !dep_reset && !pick[0] && state_r.trst == 16'h0000
                                  |=> state_r.acc == 32'h0000_0000)
    else $error("Inverse state not reset with zero reset delay");

  COV_S1_TRIP: cover property ($rose(prot.stage1_trip));
  COV_S2_TRIP: cover property ($rose(prot.stage1_second_trip));
  COV_ALARM: cover property ($rose(prot.stage4_alarm));
  COV_INV_TRIP: cover property (inverse && $rose(prot.stage1_trip));
endmodule // sefs_scheme

//--- sefs_front_end.sv
`timescale 1ns/10ps
module sefs_front_end import sefs_pkg::*; (
  // Clock
  input  wire logic          core_clk,
  // Fault scene set by the bench
  input  wire logic [DW-1:0] fault_ma,
  input  wire logic [1:0]    fault_dir,
  input  wire logic [DW-1:0] fault_volt,
  input  wire logic [DW-1:0] fault_pow,
  input  wire logic [DW-1:0] fault_rate,
  // Measured quantities
  output sefs_meas_t         meas
);
  // ****************************************
  // Measurement register
  // ****************************************
  // Only the filtered fundamental magnitude is handed on, so harmonics never reach the comparators.
  always_ff @(posedge core_clk) begin
    meas <= '{current: fault_ma, voltage: fault_volt, power: fault_pow,
              fwd: fault_dir[1], rev: fault_dir[0], curve_rate: fault_rate};
  end
endmodule // sefs_front_end

//--- sefs_scheme_bench.sv
`timescale 1ns/10ps
module sefs_scheme_bench import sefs_pkg::*; ;
  localparam int TK = 4;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dirc;
    logic [15:0] ma;
    logic [1:0]  dir;
    logic [15:0] volt;
    logic [15:0] pow;
    logic        vtf;
    logic [3:0]  blk;
    logic [3:0]  exp;
  } sefs_row_t;
  logic          core_clk;
  logic          nrst;
  sefs_bus_t     bus;
  logic [DW-1:0] rdata;
  sefs_meas_t    meas;
  sefs_char_t    curve_family;
  logic [2:0]    inverse_curve_select;
  logic [3:0]    block_input;
  logic          vt_failure;
  sefs_out_t     prot;
  logic [9:0]    pv;
  logic [DW-1:0] f_ma, f_volt, f_pow, f_rate;
  logic [1:0]    f_dir;
  int            failures = 0;
  int            comparisons = 0;
  int            cycles = 0;
  logic [20:0]   regs [12] = '{{5'h00, 16'h0000}, {5'h01, 16'h0000}, {5'h02, 16'h0032}, {5'h06, 16'h0064},
    {5'h0A, 16'h0064}, {5'h0B, 16'h03E8}, {5'h0C, 16'h0000}, {5'h0D, 16'h03E8}, {5'h0E, 16'h0000},
    {5'h0F, 16'h001E}, {5'h10, 16'h0000}, {5'h11, 16'h0000}};
  sefs_row_t     rows [13] = '{
    '{16'h000F, 16'h0000, 16'h003C, 2'h2, 16'h0028, 16'h0000, 1'h0, 4'h0, 4'hF},
    '{16'h000F, 16'h0000, 16'h003C, 2'h1, 16'h0028, 16'h0000, 1'h0, 4'h0, 4'h0},
    '{16'h000F, 16'h0055, 16'h003C, 2'h1, 16'h0028, 16'h0000, 1'h0, 4'h0, 4'hF},
    '{16'h000F, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h0, 4'hF},
    '{16'h000F, 16'h0000, 16'h003C, 2'h2, 16'h0014, 16'h0000, 1'h0, 4'h0, 4'h0},
    '{16'h0000, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h0, 4'h0},
    '{16'h000F, 16'h00AA, 16'h0031, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h0, 4'h0},
    '{16'h000F, 16'h00AA, 16'h0032, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h0, 4'hF},
    '{16'h000F, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h5, 4'hA},
    '{16'h004F, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0000, 1'h1, 4'h0, 4'hE},
    '{16'h002F, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0000, 1'h0, 4'h0, 4'h0},
    '{16'h002F, 16'h00AA, 16'h003C, 2'h0, 16'h0000, 16'h0001, 1'h0, 4'h0, 4'hF},
    '{16'h000F, 16'h00E4, 16'h003C, 2'h2, 16'h0028, 16'h0000, 1'h0, 4'h0, 4'h5}};

  assign pv = prot;

  sefs_scheme #(.TICK_CYCLES(TK)) sefs_scheme_i (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .meas(meas), .curve_family(curve_family), .inverse_curve_select(inverse_curve_select),
    .block_input(block_input), .vt_failure(vt_failure), .prot(prot));
  sefs_front_end sefs_front_end_i (.core_clk(core_clk), .fault_ma(f_ma), .fault_dir(f_dir),
    .fault_volt(f_volt), .fault_pow(f_pow), .fault_rate(f_rate), .meas(meas));

  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A gap cycle follows each access so the strobe is never assigned twice in one step.
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1;
    check("read data", 32'(rdata), 32'(exp));
    @(posedge core_clk);
  endtask

  task automatic wait_on(input int b, input int lo, input int hi, input string what);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      #1;
    end while (pv[b] !== 1'b1 && n < hi + 2);
    check(what, 32'(n >= lo && n <= hi), 32'h1);
    @(posedge core_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    bus = '0;
    {f_ma, f_volt, f_pow, f_rate, f_dir} = '0;
    block_input = 4'h0;
    vt_failure = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    check("family", 32'(curve_family), 32'h0);
    @(posedge core_clk);
    foreach (regs[i]) rd(regs[i][20:16], regs[i][15:0]);
    wr(TMS_IDX, 16'h0123);
    wr(STAT_IDX, 16'hFFFF);
    wr(5'h1F, 16'hFFFF);
    rd(TMS_IDX, 16'h0123);
    rd(STAT_IDX, 16'h0000);
    rd(5'h1F, 16'h0000);
    for (int c = 0; c < 5; c++) begin
      wr(CTRL_IDX, 16'(c << 10));
      wr(DIRC_IDX, 16'((c % 4) << 8));
      #1;
      check("family", 32'(curve_family), 32'(c));
      check("curve", 32'(inverse_curve_select), 32'(c % 4));
      @(posedge core_clk);
    end
    foreach (rows[i]) begin
      wr(CTRL_IDX, rows[i].ctrl);
      wr(DIRC_IDX, rows[i].dirc);
      f_ma <= rows[i].ma;
      f_dir <= rows[i].dir;
      f_volt <= rows[i].volt;
      f_pow <= rows[i].pow;
      vt_failure <= rows[i].vtf;
      block_input <= rows[i].blk;
      repeat (6) @(posedge core_clk);
      #1;
      check("instant", 32'(prot.instant_trip), 32'(rows[i].exp));
      check("high speed", 32'(prot.stage1_high_speed_pickup), 32'(rows[i].exp[0]));
      @(posedge core_clk);
    end
    f_ma <= 16'h0000;
    block_input <= 4'h0;
    vt_failure <= 1'b0;
    wr(DIRC_IDX, 16'h00AA);
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_IDX, 16'(1 << s));
      wr(DLY_IDX + 5'(s), 16'h0003);
      f_ma <= 16'h003C;
      wait_on(s == 0 ? 0 : s + 1, 3 * TK, 3 * TK + 7, "stage delay");
      f_ma <= 16'h0000;
      repeat (4) @(posedge core_clk);
    end
    wr(CTRL_IDX, 16'h0002);
    f_ma <= 16'h003C;
    repeat (8) @(posedge core_clk);
    f_ma <= 16'h0000;
    repeat (2) @(posedge core_clk);
    f_ma <= 16'h003C;
    wait_on(2, 3 * TK, 3 * TK + 7, "restart");
    f_ma <= 16'h0000;
    wr(CTRL_IDX, 16'h0001);
    wr(DLY12_IDX, 16'h0002);
    f_ma <= 16'h003C;
    wait_on(0, 3 * TK, 3 * TK + 7, "first trip");
    repeat (16) @(posedge core_clk);
    #1;
    check("second off", 32'(prot.stage1_second_trip), 32'h0);
    @(posedge core_clk);
    f_ma <= 16'h0000;
    wr(CTRL_IDX, 16'h0011);
    f_ma <= 16'h003C;
    wait_on(0, 3 * TK, 3 * TK + 7, "first trip");
    wait_on(1, 2 * TK, 2 * TK + 6, "second delay");
    f_ma <= 16'h0000;
    wr(TMS_IDX, 16'h0001);
    wr(CTRL_IDX, 16'h0401);
    f_rate <= 16'h0100;
    f_ma <= 16'h003C;
    wait_on(0, 3 * TK, 4 * TK + 6, "inverse");
    // A short gap keeps the integrator, a gap past the reset delay clears it.
    wr(TRST_IDX, 16'h0001);
    f_ma <= 16'h0000;
    repeat (8) @(posedge core_clk);
    f_ma <= 16'h003C;
    wait_on(0, 1, 6, "reset hold");
    f_ma <= 16'h0000;
    repeat (60) @(posedge core_clk);
    f_ma <= 16'h003C;
    wait_on(0, 3 * TK, 4 * TK + 6, "reset done");
    summarize();
  end
endmodule // sefs_scheme_bench
